// *** bench/fdc_drive_decode_rate_regs_tb.sv ***
/*
 * Self-checking bench for the drive decode, tape and rate registers.
 * Assumes fdcdr_host as bus master and a 250 MHz ref_clk.
 */
`default_nettype none
module fdc_drive_decode_rate_regs_tb
   import fdcdr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic           ref_clk, arst_n, ioWr, ioRd, enhancedMode, swapDrives, fmMode;
   logic           drive_rate_pin0, drive_rate_pin1, softReset, powerDown;
   logic [9:0]     ioAddr;
   logic [7:0]     ioWrData, ioRdData, ioRdOe, driveTypeCfg, bootDriveCfg;
   logic [1:0]     effRate;
   logic [2:0]     precompSel;
   logic [17:0]    precompDelayPs;
   logic [10:0]    dataRateKbps;
   fdcdr_pins_type pins;
   int             failCount = 0;
   int             nChecks = 0;

   fdcdr_regs dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWr(ioWr),
      .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdOe(ioRdOe),
      .enhancedMode(enhancedMode), .swapDrives(swapDrives), .fmMode(fmMode),
      .driveTypeCfg(driveTypeCfg), .bootDriveCfg(bootDriveCfg),
      .drive_rate_pin0(drive_rate_pin0), .drive_rate_pin1(drive_rate_pin1),
      .drive_sel_out0(pins.selOut0), .drive_sel_out1(pins.selOut1),
      .motor_on_out0(pins.motOut0), .motor_on_out1(pins.motOut1),
      .softReset(softReset), .powerDown(powerDown), .effRate(effRate),
      .precompSel(precompSel), .precompDelayPs(precompDelayPs),
      .dataRateKbps(dataRateKbps));
   fdcdr_host host_u (.ref_clk(ref_clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
      .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdOe(ioRdOe));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // ------------------------------------------------------------
   // Checking and expected values
   // ------------------------------------------------------------
   task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic fdcdr_pins_type decode(input logic sw, input logic [7:0] digital_output_reg);
      fdcdr_pins_type p;
      p.selOut1 = digital_output_reg[1];
      p.selOut0 = (sw && !digital_output_reg[1]) ? ~digital_output_reg[0] : digital_output_reg[0];
      p.motOut1 = 1'b1;
      p.motOut0 = ~digital_output_reg[4 + digital_output_reg[1:0]];
      return p;
   endfunction
   function automatic logic [17:0] pdly(input logic [2:0] p, input logic [1:0] r);
      case (p)
         3'h1:    return PRE_PS_1;
         3'h2:    return PRE_PS_2;
         3'h3:    return PRE_PS_3;
         3'h4:    return PRE_PS_4;
         3'h5:    return PRE_PS_5;
         3'h6:    return PRE_PS_6;
         3'h7:    return PRE_PS_0;
         default: return (r == RATE_1M) ? PRE_PS_1 : PRE_PS_3;
      endcase
   endfunction
   function automatic logic [10:0] kbps(input logic [1:0] r, input logic fm);
      logic [10:0] k;
      case (r)
         RATE_500: k = KBPS_500;
         RATE_300: k = KBPS_300;
         RATE_250: k = KBPS_250;
         default:  k = KBPS_1000;
      endcase
      return fm ? (k >> 1) : k;
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic testReset();
      chk(18'(pins), 18'(decode(1'b0, DIGOUT_RESET)), "reset pins");
      chk(18'(effRate), 18'(RATE_250), "reset rate");
      chk(18'(precompSel), 18'(PRE_DEFAULT), "reset precomp");
      chk(18'(dataRateKbps), 18'(KBPS_250), "reset kbps");
   endtask
   // Selected motor off while the others are on catches a wrong index
   task automatic testDecode();
      logic [7:0] d;
      for (int s = 0; s < 2; s++) begin
         swapDrives = s[0];
         for (int k = 0; k < 8; k++) begin
            d[7:4] = k[2] ? (4'h1 << k[1:0]) : ~(4'h1 << k[1:0]);
            d[3:0] = {2'h1, k[1:0]};
            host_u.wr(ADDR_DIGOUT, d);
            chk(18'(pins), 18'(decode(s[0], d)), "decode");
         end
      end
      swapDrives = 1'b0;
   endtask
   task automatic testTape();
      logic [7:0] d, oe, e;
      host_u.wr(ADDR_TAPE, 8'hfe);
      host_u.rd(ADDR_TAPE, d, oe);
      chk(18'(d), 18'h2, "tape data");
      chk(18'(oe), 18'(TAPE_TRI_OE), "tape oe");
      enhancedMode = 1'b1;
      drive_rate_pin0 = 1'b1;
      host_u.wr(ADDR_TAPE, 8'hfd);
      for (int s = 0; s < 4; s++) begin
         host_u.wr(ADDR_DIGOUT, {6'h01, s[1:0]});
         host_u.rd(ADDR_TAPE, d, oe);
         e = {2'h1, driveTypeCfg[2*s +: 2], bootDriveCfg[1:0], 2'h1};
         chk(18'(d), 18'(e), "tape enh");
         chk(18'(oe), 18'(ALL_OE), "tape enh oe");
      end
      enhancedMode = 1'b0;
   endtask
   task automatic testRate();
      logic [7:0] d, oe;
      host_u.rd(ADDR_RATESEL, d, oe);
      chk(18'(oe), 18'h0, "rate select unreadable");
      for (int i = 0; i < 32; i++) begin
         fmMode = i[0] ^ i[2];
         host_u.wr(ADDR_RATESEL, {3'h0, i[4:2], i[1:0]});
         chk(18'(precompSel), 18'(i[4:2]), "precomp");
         chk(precompDelayPs, pdly(i[4:2], i[1:0]), "delay");
         chk(18'(dataRateKbps), 18'(kbps(i[1:0], fmMode)), "kbps");
      end
      host_u.setRate(RATE_300);
      chk(18'(effRate), 18'(RATE_300), "config control rate");
      host_u.wr(ADDR_RATESEL, {6'h00, RATE_1M});
      chk(18'(effRate), 18'(RATE_1M), "rate select rate");
   endtask
   task automatic testSoft();
      host_u.wr(ADDR_RATESEL, 8'h0d);
      host_u.wr(ADDR_DIGOUT, 8'h00);
      chk(18'(softReset), 18'h1, "digital output reset");
      host_u.wr(ADDR_DIGOUT, 8'h04);
      chk(18'({precompSel, effRate}), 18'h0d, "rate select kept");
      host_u.wr(ADDR_RATESEL, 8'h8d);
      chk(18'(softReset), 18'h1, "sw reset");
      @(negedge ref_clk);
      chk(18'(softReset), 18'h0, "sw reset clear");
      arst_n = 1'b0;
      @(negedge ref_clk);
      arst_n = 1'b1;
      chk(18'({precompSel, effRate}), 18'(RATESEL_RESET), "hard reset");
      chk(18'(pins), 18'(decode(1'b0, DIGOUT_RESET)), "hard reset pins");
   endtask
   task automatic testPower();
      logic [7:0] d, oe;
      host_u.wr(ADDR_DIGOUT, 8'h04);
      host_u.wr(ADDR_RATESEL, 8'h42);
      chk(18'(powerDown), 18'h1, "power down");
      host_u.rd(ADDR_DATA, d, oe);
      @(negedge ref_clk);
      chk(18'(powerDown), 18'h0, "wake data");
      host_u.wr(ADDR_RATESEL, 8'h42);
      chk(18'(powerDown), 18'h1, "power down again");
      host_u.wr(ADDR_DIGOUT, 8'h00);
      @(negedge ref_clk);
      chk(18'(powerDown), 18'h0, "wake reset");
   endtask
   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      enhancedMode = 1'b0;
      swapDrives = 1'b0;
      fmMode = 1'b0;
      driveTypeCfg = 8'h1b;
      bootDriveCfg = 8'hf9;
      drive_rate_pin0 = 1'b0;
      drive_rate_pin1 = 1'b0;
      repeat (4) @(negedge ref_clk);
      arst_n = 1'b1;
      testReset();
      testDecode();
      testTape();
      testRate();
      testSoft();
      testPower();
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      failCount++;
      $display("FAIL t=%0t run did not finish", $time);
      complete_run();
   end
endmodule
`default_nettype wire

// *** bench/fdcdr_host.sv ***
/*
 * Host processor model: single-byte reads and writes on the I/O strobes.
 * Assumes callers start at a falling edge of ref_clk.
 */
`default_nettype none
module fdcdr_host
   import fdcdr_pkg::*;
(
   // Clock
   input  wire logic       ref_clk,
   // I/O bus
   output logic      [9:0] ioAddr,
   output logic            ioWr,
   output logic            ioRd,
   output logic      [7:0] ioWrData,
   input  wire logic [7:0] ioRdData,
   input  wire logic [7:0] ioRdOe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ioAddr   = 10'h000;
      ioWr     = 1'b0;
      ioRd     = 1'b0;
      ioWrData = 8'h00;
   end
   // One strobe cycle then a quiet one, so strobes never share a time step
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      ioAddr   = a;
      ioWrData = d;
      ioWr     = 1'b1;
      @(negedge ref_clk);
      ioWr     = 1'b0;
   endtask
   // Read data stands one cycle only, so it is taken as the strobe drops
   task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic [7:0] oe);
      @(negedge ref_clk);
      ioAddr = a;
      ioRd   = 1'b1;
      @(negedge ref_clk);
      d      = ioRdData;
      oe     = ioRdOe;
      ioRd   = 1'b0;
   endtask
   task automatic setRate(input logic [1:0] r);
      wr(ADDR_CFGCTL, {6'h00, r});
   endtask
endmodule
`default_nettype wire

// *** core/fdcdr_regs.sv ***
/*
 * Digital output, tape/boot/drive-type and data rate select registers with
 * the external two-to-four drive decode.
 * Assumes host strobes are one-cycle pulses on ref_clk; config bytes come
 * from logic on the same clock; drive rate pins are asynchronous.
 */
`default_nettype none

// Behaviour
// - Normal external decode: select pins copy select bits; motor0 low if selected motor on.
// - Swapped decode: code 00 gives out1=0,out0=1; code 01 gives both low.
// - Normal mode tape register stores bits 1:0; bits 7:2 float on read.
// - Enhanced mode: synchronised drive rate pins read in bits 6,7; reset-free.
// - Enhanced mode: bits 3,2 return boot drive config bits 1,0.
// - Enhanced mode: bits 5:4 return drive type pair chosen by select bits.
// - Tape select field bits 1:0 read/write, same in both modes.
// - Rate select register is write-only with reset, power, precomp, rate fields.
// - Effective rate follows the latest write of rate select or config control.
// - Soft reset keeps rate select register; hard reset loads 02h.
// - Precomp code maps to fixed delays; 000 uses rate-dependent default.
// - Rate codes give 500/300/250/1000 kbps MFM, FM half.
// - Software reset bit resets controller like the digital output reset, then self-clears.
// - Power down bit stops clocks until soft reset or data/status access.
module fdcdr_regs
   import fdcdr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   // Host I/O bus
   input  wire logic [9:0]  ioAddr,
   input  wire logic        ioWr,
   input  wire logic        ioRd,
   input  wire logic [7:0]  ioWrData,
   output logic      [7:0]  ioRdData,
   output logic      [7:0]  ioRdOe,
   // Mode and configuration
   input  wire logic        enhancedMode,
   input  wire logic        swapDrives,
   input  wire logic        fmMode,
   input  wire logic [7:0]  driveTypeCfg,
   input  wire logic [7:0]  bootDriveCfg,
   // Drive cable
   input  wire logic        drive_rate_pin0,
   input  wire logic        drive_rate_pin1,
   output logic             drive_sel_out0,
   output logic             drive_sel_out1,
   output logic             motor_on_out0,
   output logic             motor_on_out1,
   // Controller control
   output logic             softReset,
   output logic             powerDown,
   output logic      [1:0]  effRate,
   output logic      [2:0]  precompSel,
   output logic      [17:0] precompDelayPs,
   output logic      [10:0] dataRateKbps
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic wrTo(input logic [9:0] a, input logic w, input logic [9:0] t);
      return w && (a == t);
   endfunction

   function automatic logic [10:0] rateKbps(input logic [1:0] r);
      unique case (r)
         RATE_500: return KBPS_500;
         RATE_300: return KBPS_300;
         RATE_250: return KBPS_250;
         RATE_1M:  return KBPS_1000;
      endcase
   endfunction

   function automatic logic [17:0] precompPs(input logic [2:0] p, input logic [1:0] r);
      unique case (p)
         3'h0: return (r == RATE_1M) ? PRE_PS_1 : PRE_PS_3;
         3'h1: return PRE_PS_1;
         3'h2: return PRE_PS_2;
         3'h3: return PRE_PS_3;
         3'h4: return PRE_PS_4;
         3'h5: return PRE_PS_5;
         3'h6: return PRE_PS_6;
         3'h7: return PRE_PS_0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   fdcdr_digout_type  digOut_ff,   nxt_digOut;
   fdcdr_ratesel_type rateSel_ff,  nxt_rateSel;
   fdcdr_pins_type    pins_ff,     nxt_pins;
   logic [1:0]        tape_ff,     nxt_tape;
   logic [1:0]        rate_ff,     nxt_rate;
   logic              pwrDn_ff,    nxt_pwrDn;
   logic [7:0]        rdData_ff,   nxt_rdData;
   logic [7:0]        rdOe_ff,     nxt_rdOe;
   logic [1:0]        rateMeta_ff, rateSync_ff;
   logic              wrDigOut, wrTape, wrRateSel, wrCfgCtl, rdDigOut, rdTape, wakeAcc;
   logic [1:0]        typePair;

   always_comb begin
      wrDigOut  = wrTo(ioAddr, ioWr, ADDR_DIGOUT);
      wrTape    = wrTo(ioAddr, ioWr, ADDR_TAPE);
      wrRateSel = wrTo(ioAddr, ioWr, ADDR_RATESEL);
      wrCfgCtl  = wrTo(ioAddr, ioWr, ADDR_CFGCTL);
      rdDigOut  = wrTo(ioAddr, ioRd, ADDR_DIGOUT);
      rdTape    = wrTo(ioAddr, ioRd, ADDR_TAPE);
      wakeAcc   = wrTo(ioAddr, ioWr | ioRd, ADDR_RATESEL) | wrTo(ioAddr, ioWr | ioRd, ADDR_DATA);
   end

   always_comb begin
      nxt_digOut = wrDigOut ? fdcdr_digout_type'(ioWrData) : digOut_ff;
      // Bits 7:2 are never stored, whatever the mode
      nxt_tape = wrTape ? ioWrData[1:0] : tape_ff;
      nxt_rateSel = rateSel_ff;
      nxt_rateSel.swReset = 1'b0;
      if (wrRateSel) begin
         nxt_rateSel = fdcdr_ratesel_type'(ioWrData);
      end
      nxt_rate = rate_ff;
      if (wrRateSel) begin
         nxt_rate = ioWrData[1:0];
      end else if (wrCfgCtl) begin
         nxt_rate = ioWrData[CFGCTL_RATE_HI:CFGCTL_RATE_LO];
      end
      // Setting power down wins over the wake caused by the same write
      nxt_pwrDn = pwrDn_ff;
      if (wrRateSel && ioWrData[6]) begin
         nxt_pwrDn = 1'b1;
      end else if (wakeAcc || softReset) begin
         nxt_pwrDn = 1'b0;
      end
   end

   // Of these flops soft reset reaches only pwrDn_ff, so rate select and tape bits survive it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         digOut_ff  <= fdcdr_digout_type'(DIGOUT_RESET);
         rateSel_ff <= fdcdr_ratesel_type'(RATESEL_RESET);
         tape_ff    <= TAPE_RESET;
         rate_ff    <= RATESEL_RESET[1:0];
         pwrDn_ff   <= 1'b0;
      end else begin
         digOut_ff  <= nxt_digOut;
         rateSel_ff <= nxt_rateSel;
         tape_ff    <= nxt_tape;
         rate_ff    <= nxt_rate;
         pwrDn_ff   <= nxt_pwrDn;
      end
   end

   // ----------------------------------------------------------------
   // Drive rate pin synchroniser
   // ----------------------------------------------------------------
   // No reset: pin levels must read through any reset
   always_ff @(posedge ref_clk) begin
      rateMeta_ff <= {drive_rate_pin1, drive_rate_pin0};
      rateSync_ff <= rateMeta_ff;
   end

   // ----------------------------------------------------------------
   // External drive decode
   // ----------------------------------------------------------------
   // Decoded from the next register value so pins move with it, from one flop each
   always_comb begin
      nxt_pins.selOut1 = nxt_digOut.drvSel[1];
      nxt_pins.selOut0 = nxt_digOut.drvSel[0];
      if (swapDrives && !nxt_digOut.drvSel[1]) begin
         nxt_pins.selOut0 = !nxt_digOut.drvSel[0];
      end
      nxt_pins.motOut1 = 1'b1;
      nxt_pins.motOut0 = !nxt_digOut.motEn[nxt_digOut.drvSel];
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Same levels as the cleared register decodes to with swapDrives low, so release is seamless unswapped
         pins_ff <= fdcdr_pins_type'(PINS_RESET);
      end else begin
         pins_ff <= nxt_pins;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   always_comb begin
      unique case (digOut_ff.drvSel)
         2'h0: typePair = driveTypeCfg[1:0];
         2'h1: typePair = driveTypeCfg[3:2];
         2'h2: typePair = driveTypeCfg[5:4];
         2'h3: typePair = driveTypeCfg[7:6];
      endcase
      nxt_rdData = 8'h00;
      nxt_rdOe   = 8'h00;
      if (rdDigOut) begin
         nxt_rdData = digOut_ff;
         nxt_rdOe   = ALL_OE;
      end else if (rdTape && enhancedMode) begin
         nxt_rdData = {rateSync_ff, typePair, bootDriveCfg[1:0], tape_ff};
         nxt_rdOe   = ALL_OE;
      end else if (rdTape) begin
         nxt_rdData = {6'h00, tape_ff};
         nxt_rdOe   = TAPE_TRI_OE;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdData_ff <= 8'h00;
         rdOe_ff   <= 8'h00;
      end else begin
         rdData_ff <= nxt_rdData;
         rdOe_ff   <= nxt_rdOe;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign ioRdData       = rdData_ff;
   assign ioRdOe         = rdOe_ff;
   assign drive_sel_out1 = pins_ff.selOut1;
   assign drive_sel_out0 = pins_ff.selOut0;
   assign motor_on_out1  = pins_ff.motOut1;
   assign motor_on_out0  = pins_ff.motOut0;
   assign softReset      = !digOut_ff.resetN || rateSel_ff.swReset;
   assign powerDown      = pwrDn_ff;
   assign effRate        = rate_ff;
   assign precompSel     = rateSel_ff.precomp;
   assign precompDelayPs = precompPs(rateSel_ff.precomp, rate_ff);
   // FM runs at half the MFM rate
   assign dataRateKbps   = fmMode ? (rateKbps(rate_ff) >> 1) : rateKbps(rate_ff);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   a_normal_sel_pins: assert property (
      (wrDigOut && !swapDrives) |=> (drive_sel_out1 == $past(ioWrData[1])
                                     && drive_sel_out0 == $past(ioWrData[0])))
      else $error("normal decode select pins wrong");

   a_motor_follow: assert property (
      wrDigOut |=> (motor_on_out0 == !$past(ioWrData[4 + ioWrData[1:0]]) && motor_on_out1))
      else $error("motor pin does not follow selected enable");

   a_swap_code01: assert property (
      (wrDigOut && swapDrives && ioWrData[1:0] == 2'h1) |=> (!drive_sel_out1 && !drive_sel_out0))
      else $error("swapped code 01 not both low");

   a_swap_code00: assert property (
      (wrDigOut && swapDrives && ioWrData[1:0] == 2'h0) |=> (!drive_sel_out1 && drive_sel_out0))
      else $error("swapped code 00 wrong");

   a_tape_float: assert property (
      (rdTape && !enhancedMode && !rdDigOut)
         |=> (ioRdOe == TAPE_TRI_OE && ioRdData[1:0] == tape_ff))
      else $error("normal tape read drives upper bits");

   a_enh_tape_read: assert property (
      (rdTape && enhancedMode) |=> (ioRdData[3:2] == $past(bootDriveCfg[1:0])
                                    && ioRdData[7:6] == $past(rateSync_ff)))
      else $error("enhanced tape read boot or rate bits wrong");

   a_type_pair: assert property (
      (rdTape && enhancedMode && digOut_ff.drvSel == 2'h3)
         |=> ioRdData[5:4] == $past(driveTypeCfg[7:6]))
      else $error("drive type pair not chosen by select");

   a_tape_upper_drop: assert property (
      wrTape |=> (tape_ff == $past(ioWrData[1:0])))
      else $error("tape select field not stored");

   a_rate_latest: assert property (
      (wrCfgCtl && !wrRateSel) |=> effRate == $past(ioWrData[1:0]))
      else $error("config control write did not set rate");

   a_swreset_pulse: assert property (
      (wrRateSel && ioWrData[7])
         |=> rateSel_ff.swReset ##1 (!rateSel_ff.swReset || $past(wrRateSel)))
      else $error("software reset bit not self clearing");

   a_power_wake: assert property (
      (powerDown && wakeAcc && !wrRateSel) |=> !powerDown)
      else $error("power down not left on access");

   a_precomp_default: assert property (
      (precompSel == PRE_DEFAULT && effRate == RATE_1M) |-> precompDelayPs == PRE_PS_1)
      else $error("default precomp wrong at 1 Mbps");

   c_swap_write:   cover property (wrDigOut && swapDrives ##1 !drive_sel_out0);
   c_enh_read:     cover property (rdTape && enhancedMode ##1 ioRdOe == ALL_OE);
   c_power_cycle:  cover property (wrRateSel && ioWrData[6] ##[1:20] !powerDown);
   c_ctl_then_sel: cover property (wrCfgCtl ##[1:10] wrRateSel);
endmodule
`default_nettype wire

// *** include/fdcdr_pkg.sv ***
/*
 * Constants and types for the drive decode, tape/boot/type and data rate registers.
 * Assumes an I/O bus whose strobes are synchronous to ref_clk.
 */
`default_nettype none
package fdcdr_pkg;
   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [9:0] ADDR_DIGOUT  = 10'h3f2;
   localparam logic [9:0] ADDR_TAPE    = 10'h3f3;
   localparam logic [9:0] ADDR_RATESEL = 10'h3f4;
   localparam logic [9:0] ADDR_DATA    = 10'h3f5;
   localparam logic [9:0] ADDR_CFGCTL  = 10'h3f7;

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] DIGOUT_RESET   = 8'h00;
   localparam logic [7:0] RATESEL_RESET  = 8'h02;
   localparam logic [1:0] TAPE_RESET     = 2'h0;
   localparam logic [7:0] TAPE_TRI_OE    = 8'h03;
   localparam logic [7:0] ALL_OE         = 8'hff;
   localparam int         CFGCTL_RATE_LO = 0;
   localparam int         CFGCTL_RATE_HI = 1;
   // Cable levels of the cleared register, unswapped: selects low, motors off
   localparam logic [3:0] PINS_RESET     = 4'h3;

   // ----------------------------------------------------------------
   // Precompensation codes and delays in picoseconds
   // ----------------------------------------------------------------
   localparam logic [2:0]  PRE_DEFAULT = 3'h0;
   localparam logic [2:0]  PRE_OFF     = 3'h7;
   localparam logic [17:0] PRE_PS_1    = 18'd41670;
   localparam logic [17:0] PRE_PS_2    = 18'd83340;
   localparam logic [17:0] PRE_PS_3    = 18'd125000;
   localparam logic [17:0] PRE_PS_4    = 18'd166670;
   localparam logic [17:0] PRE_PS_5    = 18'd208330;
   localparam logic [17:0] PRE_PS_6    = 18'd250000;
   localparam logic [17:0] PRE_PS_0    = 18'd0;

   // ----------------------------------------------------------------
   // Data rate codes and MFM rates in kbps
   // ----------------------------------------------------------------
   localparam logic [1:0]  RATE_500  = 2'h0;
   localparam logic [1:0]  RATE_300  = 2'h1;
   localparam logic [1:0]  RATE_250  = 2'h2;
   localparam logic [1:0]  RATE_1M   = 2'h3;
   localparam logic [10:0] KBPS_500  = 11'd500;
   localparam logic [10:0] KBPS_300  = 11'd300;
   localparam logic [10:0] KBPS_250  = 11'd250;
   localparam logic [10:0] KBPS_1000 = 11'd1000;

   typedef struct packed {
      logic [3:0] motEn;
      logic       dmaEn;
      logic       resetN;
      logic [1:0] drvSel;
   } fdcdr_digout_type;

   typedef struct packed {
      logic       swReset;
      logic       powerDown;
      logic       zero;
      logic [2:0] precomp;
      logic [1:0] rate;
   } fdcdr_ratesel_type;

   typedef struct packed {
      logic selOut1;
      logic selOut0;
      logic motOut1;
      logic motOut0;
   } fdcdr_pins_type;
endpackage
`default_nettype wire
